// ---- rtl/hpc_slot_ctrl.v ----
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "hpc_defs.vh"
// Functional notes
// (R1) Fault pin low on any aux or main fault
// (R2) Aux fault clears only when aux request drops
// (R3) Main fault clears only when main request drops
// (R4) Persisting fault past filter timeout kills main
// (R5) Two switch inputs filtered, readable in common status
// (R6) Power good only while all rails good
// (R7) Force-on keeps channel on despite faults
// (R8) Inhibit bit makes force-on ignored
// (R9) Overtemperature overrides force-on
// (R10) Per-slot state register readable by software
// (R11) Slot power off reported after rails below threshold
// (R12) Sense comparator overcurrent feeds fault handling
// (R13) Switch inputs debounced about 5 ms
// (R14) Interrupt on fault unless masked, cleared by status
// (R15) Address select sampled once after reset
// (R16) All asynchronous inputs synchronised before use
module hpc_slot_ctrl #(
  parameter DEBOUNCE_CYC = `HPC_DEBOUNCE_CYC
) (
  input wire CLK,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [1:0] STANDBY_RAIL_REQUEST,
  input wire [1:0] MAIN_RAIL_REQUEST,
  input wire [1:0] DIAG_FORCE_CHANNEL_N,
  input wire [1:0] SENSE_LOW_12V,
  input wire [1:0] SENSE_LOW_3V3,
  input wire [1:0] AUX_OVERCURRENT,
  input wire [1:0] AUX_UNDERVOLT,
  input wire [1:0] MAIN_UNDERVOLT,
  input wire [1:0] OVER_TEMP,
  input wire [1:0] FAULT_TIMER_CAP,
  input wire [1:0] RAILS_GOOD,
  input wire [1:0] RAILS_BELOW_LOW,
  input wire [1:0] GP_SWITCH_IN_FIRST,
  input wire [1:0] GP_SWITCH_IN_SECOND,
  input wire [2:0] BUS_ADDR_SELECT,
  output reg [1:0] AUX_GATE_ON,
  output reg [1:0] MAIN_GATE_ON,
  output reg [1:0] SLOT_FAULT_N,
  output reg [1:0] SLOT_POWER_GOOD_N,
  output wire INT_N
);
  // Synchronised slot inputs, 14 per slot
  wire [1:0] aux_req;
  wire [1:0] main_req;
  wire [1:0] force_n;
  wire [1:0] oc12;
  wire [1:0] oc33;
  wire [1:0] aux_oc;
  wire [1:0] aux_uv;
  wire [1:0] main_uv;
  wire [1:0] ot;
  wire [1:0] tmr_done;
  wire [1:0] pg_ok;
  wire [1:0] low_ok;
  wire [1:0] gp1;
  wire [1:0] gp2;
  wire [2:0] addr_sync;

  reg [1:0] aux_flt_reg;
  reg [1:0] main_flt_reg;
  reg [1:0] main_trip_reg;
  reg [1:0] pwroff_reg;
  reg [1:0] ctrl_reg;
  reg [`HPC_IRQ_W-1:0] irq_stat_reg;
  reg [`HPC_IRQ_W-1:0] irq_mask_reg;
  reg [2:0] addr_reg;
  reg addr_wait_reg;
  reg addr_done_reg;
  reg [1:0] forced;
  reg [1:0] aux_event;
  reg [1:0] main_event;
  reg [`HPC_IRQ_W-1:0] irq_set;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : slot
      // Every pin from outside passes two flops first; see (R16)
      // A one-cycle filter adds a flop but no delay worth noting
      // Standby rail request from the system side
      hpc_sync_filter #(.FILTER_CYC(1)) u_aux (
        .clk(CLK),
        .srst(SRST),
        .din(STANDBY_RAIL_REQUEST[g]),
        .dout(aux_req[g])
      );
      // Main rail request from the system side
      hpc_sync_filter #(.FILTER_CYC(1)) u_main (
        .clk(CLK),
        .srst(SRST),
        .din(MAIN_RAIL_REQUEST[g]),
        .dout(main_req[g])
      );
      // Force pin is inverted here so the reset value means not forced
      hpc_sync_filter #(.FILTER_CYC(1)) u_frc (
        .clk(CLK),
        .srst(SRST),
        .din(~DIAG_FORCE_CHANNEL_N[g]),
        .dout(force_n[g])
      );
      // Overcurrent comparators across the two sense resistors
      hpc_sync_filter #(.FILTER_CYC(1)) u_o12 (
        .clk(CLK),
        .srst(SRST),
        .din(SENSE_LOW_12V[g]),
        .dout(oc12[g])
      );
      hpc_sync_filter #(.FILTER_CYC(1)) u_o33 (
        .clk(CLK),
        .srst(SRST),
        .din(SENSE_LOW_3V3[g]),
        .dout(oc33[g])
      );
      // Standby rail comparators
      hpc_sync_filter #(.FILTER_CYC(1)) u_aoc (
        .clk(CLK),
        .srst(SRST),
        .din(AUX_OVERCURRENT[g]),
        .dout(aux_oc[g])
      );
      hpc_sync_filter #(.FILTER_CYC(1)) u_auv (
        .clk(CLK),
        .srst(SRST),
        .din(AUX_UNDERVOLT[g]),
        .dout(aux_uv[g])
      );
      // Main rail undervoltage
      hpc_sync_filter #(.FILTER_CYC(1)) u_muv (
        .clk(CLK),
        .srst(SRST),
        .din(MAIN_UNDERVOLT[g]),
        .dout(main_uv[g])
      );
      // Thermal shutdown; it must reach the gates even while forced
      hpc_sync_filter #(.FILTER_CYC(1)) u_ot (
        .clk(CLK),
        .srst(SRST),
        .din(OVER_TEMP[g]),
        .dout(ot[g])
      );
      // Filter capacitor threshold reached
      hpc_sync_filter #(.FILTER_CYC(1)) u_tmr (
        .clk(CLK),
        .srst(SRST),
        .din(FAULT_TIMER_CAP[g]),
        .dout(tmr_done[g])
      );
      // All rails in range
      hpc_sync_filter #(.FILTER_CYC(1)) u_pg (
        .clk(CLK),
        .srst(SRST),
        .din(RAILS_GOOD[g]),
        .dout(pg_ok[g])
      );
      // All rails bled below the low threshold
      hpc_sync_filter #(.FILTER_CYC(1)) u_low (
        .clk(CLK),
        .srst(SRST),
        .din(RAILS_BELOW_LOW[g]),
        .dout(low_ok[g])
      );
      // Mechanical switches get the long debounce; see (R13)
      // Contact bounce shorter than the window never reaches status
      hpc_sync_filter #(.FILTER_CYC(DEBOUNCE_CYC)) u_gp1 (
        .clk(CLK),
        .srst(SRST),
        .din(GP_SWITCH_IN_FIRST[g]),
        .dout(gp1[g])
      );
      hpc_sync_filter #(.FILTER_CYC(DEBOUNCE_CYC)) u_gp2 (
        .clk(CLK),
        .srst(SRST),
        .din(GP_SWITCH_IN_SECOND[g]),
        .dout(gp2[g])
      );
    end
    // Address straps are static levels but still cross into the clock domain
    for (g = 0; g < 3; g = g + 1) begin : adr
      hpc_sync_filter #(.FILTER_CYC(1)) u_adr (
        .clk(CLK),
        .srst(SRST),
        .din(BUS_ADDR_SELECT[g]),
        .dout(addr_sync[g])
      );
    end
  endgenerate

  // Fault events per slot; overcurrent from either sense comparator counts as main
  always @* begin
    aux_event = aux_oc | aux_uv | ot;
    main_event = oc12 | oc33 | main_uv | ot; // see (R12)
    forced = force_n & ~ctrl_reg & ~ot; // see (R8) see (R9)
    irq_set = {main_event[1] & main_req[1] & ~main_flt_reg[1], aux_event[1] & aux_req[1] & ~aux_flt_reg[1],
               main_event[0] & main_req[0] & ~main_flt_reg[0], aux_event[0] & aux_req[0] & ~aux_flt_reg[0]};
  end

  // Fault latches: a fault only clears by dropping its request
  always @(posedge CLK) begin
    if (SRST) begin
      aux_flt_reg <= 2'h0;
      main_flt_reg <= 2'h0;
      main_trip_reg <= 2'h0;
    end else begin
      aux_flt_reg <= aux_req & (aux_flt_reg | aux_event); // see (R2)
      main_flt_reg <= main_req & (main_flt_reg | main_event); // see (R3)
      // The external cap sets how long a fault may persist before main is cut
      main_trip_reg <= main_req & (main_trip_reg | (main_event & tmr_done)); // see (R4)
    end
  end

  // Gate drives, fault and power-good pins; force-on wins over the latched faults
  always @(posedge CLK) begin
    if (SRST) begin
      AUX_GATE_ON <= 2'h0;
      MAIN_GATE_ON <= 2'h0;
      SLOT_FAULT_N <= 2'h3;
      SLOT_POWER_GOOD_N <= 2'h3;
      pwroff_reg <= 2'h0;
    end else begin
      AUX_GATE_ON <= (aux_req & ~aux_flt_reg & ~ot) | forced; // see (R7) see (R9)
      MAIN_GATE_ON <= (main_req & ~main_trip_reg & ~ot) | forced; // see (R4) see (R7)
      SLOT_FAULT_N <= ~(aux_flt_reg | main_flt_reg); // see (R1)
      SLOT_POWER_GOOD_N <= ~pg_ok; // see (R6)
      pwroff_reg <= ~MAIN_GATE_ON & low_ok; // see (R11)
    end
  end

  // Address straps caught once, at the second edge after reset
  // The filter output is cleared by reset, so the first edge would capture zero
  always @(posedge CLK) begin
    if (SRST) begin
      addr_reg <= 3'h0;
      addr_wait_reg <= 1'b0;
      addr_done_reg <= 1'b0;
    end else if (!addr_wait_reg) begin
      addr_wait_reg <= 1'b1;
    end else if (!addr_done_reg) begin
      addr_reg <= addr_sync; // see (R15)
      addr_done_reg <= 1'b1;
    end
  end

  // APB slave: zero wait states, unmapped reads return zero
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  wire wr_en = PSEL & PENABLE & PWRITE;

  // Writable registers; hardware set wins over a write-one clear
  // so a fault that lands in the clearing cycle is never lost
  always @(posedge CLK) begin
    if (SRST) begin
      ctrl_reg <= `HPC_CTRL_RESET;
      irq_stat_reg <= `HPC_IRQ_RESET;
      irq_mask_reg <= `HPC_IRQ_RESET;
    end else begin
      if (wr_en && PADDR == `HPC_OFF_CTRL)
        ctrl_reg <= PWDATA[1:0];
      if (wr_en && PADDR == `HPC_OFF_IRQ_MASK)
        irq_mask_reg <= PWDATA[`HPC_IRQ_W-1:0];
      if (wr_en && PADDR == `HPC_OFF_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~PWDATA[`HPC_IRQ_W-1:0]) | irq_set; // see (R14)
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // Interrupt stays low while any unmasked status bit is set
  assign INT_N = ~|(irq_stat_reg & ~irq_mask_reg); // see (R14)

  // Read mux
  always @* begin
    case (PADDR)
      `HPC_OFF_STATE_A: PRDATA = {24'h000000, ot[0], forced[0], pwroff_reg[0], ~SLOT_POWER_GOOD_N[0],
        main_flt_reg[0], aux_flt_reg[0], MAIN_GATE_ON[0], AUX_GATE_ON[0]}; // see (R10)
      `HPC_OFF_STATE_B: PRDATA = {24'h000000, ot[1], forced[1], pwroff_reg[1], ~SLOT_POWER_GOOD_N[1],
        main_flt_reg[1], aux_flt_reg[1], MAIN_GATE_ON[1], AUX_GATE_ON[1]}; // see (R10)
      `HPC_OFF_COMMON: PRDATA = {28'h0000000, gp2[1], gp1[1], gp2[0], gp1[0]}; // see (R5)
      `HPC_OFF_CTRL: PRDATA = {30'h00000000, ctrl_reg};
      `HPC_OFF_IRQ_STAT: PRDATA = {28'h0000000, irq_stat_reg};
      `HPC_OFF_IRQ_MASK: PRDATA = {28'h0000000, irq_mask_reg};
      `HPC_OFF_ADDR: PRDATA = {29'h00000000, addr_reg};
      default: PRDATA = `HPC_ZERO32;
    endcase
  end
endmodule // hpc_slot_ctrl

// ---- rtl/hpc_defs.vh ----
`ifndef HPC_DEFS_VH
`define HPC_DEFS_VH
// Register byte offsets on the APB
`define HPC_OFF_STATE_A 12'h000
`define HPC_OFF_STATE_B 12'h004
`define HPC_OFF_COMMON 12'h008
`define HPC_OFF_CTRL 12'h00C
`define HPC_OFF_IRQ_STAT 12'h010
`define HPC_OFF_IRQ_MASK 12'h014
`define HPC_OFF_ADDR 12'h018
// Control register fields
`define HPC_CTRL_INHIB_A 0
`define HPC_CTRL_INHIB_B 1
`define HPC_CTRL_RESET 2'h0
// Slot state fields
`define HPC_ST_AUX_ON 0
`define HPC_ST_MAIN_ON 1
`define HPC_ST_AUX_FLT 2
`define HPC_ST_MAIN_FLT 3
`define HPC_ST_PGOOD 4
`define HPC_ST_PWROFF 5
`define HPC_ST_FORCED 6
`define HPC_ST_OT 7
// Interrupt status bits: aux fault A, main fault A, aux fault B, main fault B
`define HPC_IRQ_W 4
`define HPC_IRQ_RESET 4'h0
// Timing
`define HPC_CLK_MHZ 200
`define HPC_DEBOUNCE_MS 5
`define HPC_DEBOUNCE_CYC (`HPC_DEBOUNCE_MS * 1000 * `HPC_CLK_MHZ)
`define HPC_CNT_W 20
`define HPC_ZERO32 32'h00000000
`endif

// ---- rtl/hpc_sync_filter.v ----
`timescale 1ns/100ps
`include "hpc_defs.vh"
// Two-stage synchroniser followed by an optional stability filter
module hpc_sync_filter #(
  parameter FILTER_CYC = 1
) (
  input wire clk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg meta_reg;
  reg sync_reg;
  reg [`HPC_CNT_W-1:0] cnt_reg;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    meta_reg <= din;
    sync_reg <= meta_reg;
  end

  // Output follows only after the input has held a new value for FILTER_CYC cycles
  always @(posedge clk) begin
    if (srst) begin
      cnt_reg <= {`HPC_CNT_W{1'b0}};
      dout <= 1'b0;
    end else if (sync_reg == dout) begin
      cnt_reg <= {`HPC_CNT_W{1'b0}};
    end else if (cnt_reg >= FILTER_CYC - 1) begin
      cnt_reg <= {`HPC_CNT_W{1'b0}};
      dout <= sync_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // hpc_sync_filter

// ---- verif/hpc_partner.sv ----
`timescale 1ns/100ps
// Behavioural power FETs and rail comparators behind the main gate drive
module hpc_partner (
  input wire clk,
  input wire [1:0] main_on,
  output reg [1:0] rails_good = 2'h0,
  output reg [1:0] rails_low = 2'h3
);
  reg [1:0] ramp_reg = 2'h0;
  // Rails need two edges to ramp or bleed below low, but rails_good drops at the first edge after the gate turns off
  always @(posedge clk) begin
    ramp_reg <= main_on;
    rails_good <= ramp_reg & main_on;
    rails_low <= ~ramp_reg & ~main_on;
  end
endmodule // hpc_partner

// ---- verif/hpc_chk.sv ----
`timescale 1ns/100ps
module hpc_chk (
  input wire CLK,
  input wire SRST,
  input wire [1:0] STANDBY_RAIL_REQUEST,
  input wire [1:0] MAIN_RAIL_REQUEST,
  input wire [1:0] DIAG_FORCE_CHANNEL_N,
  input wire [1:0] SENSE_LOW_12V,
  input wire [1:0] AUX_UNDERVOLT,
  input wire [1:0] OVER_TEMP,
  input wire [1:0] FAULT_TIMER_CAP,
  input wire [1:0] RAILS_GOOD,
  input wire [1:0] AUX_GATE_ON,
  input wire [1:0] MAIN_GATE_ON,
  input wire [1:0] SLOT_FAULT_N,
  input wire [1:0] SLOT_POWER_GOOD_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // Eight quiet cycles cover synchroniser, filter, latch and output stages
  sequence s_aux_evt; STANDBY_RAIL_REQUEST[0] && AUX_UNDERVOLT[0]; endsequence
  sequence s_oc_evt; MAIN_RAIL_REQUEST[0] && SENSE_LOW_12V[0]; endsequence
  sequence s_idle; !STANDBY_RAIL_REQUEST[0] && !MAIN_RAIL_REQUEST[0]; endsequence
  a_fault_raise: assert property (s_aux_evt [*8] |-> !SLOT_FAULT_N[0])
    else $error("fault pin missed aux event");
  a_oc_fault: assert property (s_oc_evt [*8] |-> !SLOT_FAULT_N[0])
    else $error("fault pin missed overcurrent");
  a_fault_clear: assert property (s_idle [*8] |-> SLOT_FAULT_N[0])
    else $error("fault held with requests low");
  a_fault_cause: assert property ($fell(SLOT_FAULT_N[0]) |-> $past(STANDBY_RAIL_REQUEST[0] || MAIN_RAIL_REQUEST[0], 2))
    else $error("fault pin fell without request");
  a_gate_idle: assert property ((!MAIN_RAIL_REQUEST[0] && DIAG_FORCE_CHANNEL_N[0]) [*8] |-> !MAIN_GATE_ON[0])
    else $error("main gate on without request");
  a_main_trip: assert property ((SENSE_LOW_12V[0] && FAULT_TIMER_CAP[0] && DIAG_FORCE_CHANNEL_N[0]) [*8]
    |-> !MAIN_GATE_ON[0])
    else $error("main gate survived timer expiry");
  a_ot_override: assert property (OVER_TEMP[0] [*8] |-> !AUX_GATE_ON[0] && !MAIN_GATE_ON[0])
    else $error("gate on during overtemperature");
  a_pgood_bad: assert property (!RAILS_GOOD[0] [*8] |-> SLOT_POWER_GOOD_N[0])
    else $error("power good with bad rails");
endmodule // hpc_chk
bind hpc_slot_ctrl hpc_chk u_chk (.CLK(CLK), .SRST(SRST), .STANDBY_RAIL_REQUEST(STANDBY_RAIL_REQUEST),
  .MAIN_RAIL_REQUEST(MAIN_RAIL_REQUEST), .DIAG_FORCE_CHANNEL_N(DIAG_FORCE_CHANNEL_N), .SENSE_LOW_12V(SENSE_LOW_12V),
  .AUX_UNDERVOLT(AUX_UNDERVOLT), .OVER_TEMP(OVER_TEMP), .FAULT_TIMER_CAP(FAULT_TIMER_CAP), .RAILS_GOOD(RAILS_GOOD),
  .AUX_GATE_ON(AUX_GATE_ON), .MAIN_GATE_ON(MAIN_GATE_ON), .SLOT_FAULT_N(SLOT_FAULT_N),
  .SLOT_POWER_GOOD_N(SLOT_POWER_GOOD_N));

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`include "hpc_defs.vh"
// Compare on the falling edge so registered outputs have settled
`define CHK(n, e, v) begin @(negedge clk); samples_checked++; if ((v) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", n, e, v); end @(posedge clk); end
module tb_top;
  reg clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q = 32'h0;
  reg [1:0] sreq = 2'h0, mreq = 2'h0, frc_n = 2'h3, s12 = 2'h0, auv = 2'h0, ot = 2'h0, cap = 2'h0, gp1 = 2'h0;
  reg [2:0] strap = 3'h5;
  reg [1:0] s33 = 2'h0;
  integer n_mismatch = 0, samples_checked = 0, cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, int_n;
  wire [1:0] aux_on, main_on, fault_n, pgood_n, rgood, rlow;
  always #2.5 clk = ~clk;
  hpc_slot_ctrl #(.DEBOUNCE_CYC(8)) u_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STANDBY_RAIL_REQUEST(sreq),
    .MAIN_RAIL_REQUEST(mreq), .DIAG_FORCE_CHANNEL_N(frc_n), .SENSE_LOW_12V(s12), .SENSE_LOW_3V3(s33),
    .AUX_OVERCURRENT(2'h0), .AUX_UNDERVOLT(auv), .MAIN_UNDERVOLT(2'h0), .OVER_TEMP(ot), .FAULT_TIMER_CAP(cap),
    .RAILS_GOOD(rgood), .RAILS_BELOW_LOW(rlow), .GP_SWITCH_IN_FIRST(gp1), .GP_SWITCH_IN_SECOND(2'h0),
    .BUS_ADDR_SELECT(strap), .AUX_GATE_ON(aux_on), .MAIN_GATE_ON(main_on), .SLOT_FAULT_N(fault_n),
    .SLOT_POWER_GOOD_N(pgood_n), .INT_N(int_n));
  hpc_partner u_far (.clk(clk), .main_on(main_on), .rails_good(rgood), .rails_low(rlow));
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; read data is taken at the edge that sees pready
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    {psel, pen} <= 2'h0;
  endtask
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_reset;
    strap <= 3'h2;
    apb(0, `HPC_OFF_ADDR, 32'h0);
    `CHK("strap", 3'h5, q[2:0])
    apb(0, `HPC_OFF_STATE_A, 32'h0);
    `CHK("state_a", 4'h0, q[3:0])
    apb(0, `HPC_OFF_IRQ_STAT, 32'h0);
    `CHK("irq_rst", 4'h0, q[3:0])
    apb(0, 12'h020, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("no_err", 1'b0, pslverr)
    `CHK("int_rst", 1'b1, int_n)
  endtask
  task t_aux;
    sreq <= 2'h1;
    tick(8);
    `CHK("aux_gate", 1'b1, aux_on[0])
    auv <= 2'h1;
    tick(8);
    `CHK("aux_fault", 1'b0, fault_n[0])
    `CHK("int_set", 1'b0, int_n)
    auv <= 2'h0;
    apb(0, `HPC_OFF_STATE_A, 32'h0);
    `CHK("aux_flt", 1'b1, q[`HPC_ST_AUX_FLT])
    `CHK("aux_held", 1'b0, fault_n[0])
    apb(1, `HPC_OFF_IRQ_STAT, 32'h1);
    `CHK("int_w1c", 1'b1, int_n)
    sreq <= 2'h0;
    tick(8);
    `CHK("aux_clr", 1'b1, fault_n[0])
  endtask
  // Overcurrent latches at once but main power waits for the filter timer
  task t_main;
    apb(1, `HPC_OFF_IRQ_MASK, 32'hF);
    mreq <= 2'h1;
    tick(8);
    `CHK("main_gate", 1'b1, main_on[0])
    s12 <= 2'h1;
    tick(8);
    `CHK("oc_fault", 1'b0, fault_n[0])
    `CHK("pre_trip", 1'b1, main_on[0])
    `CHK("pgood_on", 1'b0, pgood_n[0])
    `CHK("masked", 1'b1, int_n)
    cap <= 2'h1;
    tick(12);
    `CHK("trip", 1'b0, main_on[0])
    `CHK("pgood_off", 1'b1, pgood_n[0])
    apb(0, `HPC_OFF_STATE_A, 32'h0);
    `CHK("pwroff", 1'b1, q[`HPC_ST_PWROFF])
    {s12, cap, mreq} <= 6'h0;
    tick(8);
    `CHK("main_clr", 1'b1, fault_n[0])
    apb(1, `HPC_OFF_IRQ_STAT, 32'hF);
    apb(1, `HPC_OFF_IRQ_MASK, 32'h0);
    `CHK("int_idle", 1'b1, int_n)
  endtask
  task t_force;
    {sreq, auv, frc_n} <= 6'h16;
    tick(8);
    `CHK("forced", 2'h3, {aux_on[0], main_on[0]})
    apb(1, `HPC_OFF_CTRL, 32'h1);
    tick(6);
    `CHK("inhib", 2'h0, {aux_on[0], main_on[0]})
    apb(1, `HPC_OFF_CTRL, 32'h0);
    tick(6);
    `CHK("reforced", 2'h3, {aux_on[0], main_on[0]})
    ot <= 2'h1;
    tick(8);
    `CHK("ot_off", 2'h0, {aux_on[0], main_on[0]})
    {sreq, auv, frc_n, ot} <= 8'h0C;
    tick(8);
    apb(1, `HPC_OFF_IRQ_STAT, 32'hF);
  endtask
  // Slot B, overcurrent on the 3.3 V sense only, interrupt unmasked
  task t_oc33;
    {mreq, s33} <= 4'hA;
    tick(8);
    `CHK("oc33_b", 1'b0, fault_n[1])
    `CHK("oc33_a", 1'b1, fault_n[0])
    `CHK("oc33_int", 1'b0, int_n)
    {mreq, s33} <= 4'h0;
    tick(8);
    `CHK("oc33_clr", 1'b1, fault_n[1])
    apb(1, `HPC_OFF_IRQ_STAT, 32'hF);
    `CHK("oc33_w1c", 1'b1, int_n)
  endtask
  task t_gp;
    gp1 <= 2'h3;
    tick(2);
    apb(0, `HPC_OFF_COMMON, 32'h0);
    `CHK("gp_early", 4'h0, q[3:0])
    tick(12);
    apb(0, `HPC_OFF_COMMON, 32'h0);
    `CHK("gp_late", 4'h5, q[3:0])
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    tick(3);
    srst <= 1'b0;
    t_reset;
    t_aux;
    t_main;
    t_force;
    t_oc33;
    t_gp;
    end_sim;
  end
endmodule // tb_top
